// [design/cmp_channel.sv]
`timescale 1ns/100ps
// One comparator: polarity, sync latch, per-cycle latch, edge flag
module cmp_channel
  import cmp_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic [7:0] ctrl0,
  input  wire logic [7:0] ctrl1,
  input  wire logic       flag_clear,
  // Analog side
  input  wire logic       raw_compare,
  input  wire logic       tmr1_clk,
  // Results
  output logic            result,
  output logic            ext_result,
  output logic            event_flag
);

  logic post_pol;
  logic result_q;
  logic sync_q;
  logic tclk_q;
  logic flag_q;
  logic rise;
  logic fall;

  // A disabled comparator reads low before polarity is applied
  assign post_pol = (raw_compare & ctrl0[C0_ON]) ^ ctrl0[C0_INVERT];

  // Internal result latched once per cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result_q <= 1'b0;
    else
      result_q <= post_pol;
  end

  // Falling edge of the (prescaled) Timer1 clock, sampled as a level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tclk_q <= 1'b0;
    else
      tclk_q <= tmr1_clk;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_q <= 1'b0;
    else if (tclk_q && !tmr1_clk)
      sync_q <= post_pol;
  end

  assign rise = post_pol & ~result_q;
  assign fall = ~post_pol & result_q;

  // Set wins over a simultaneous clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_q <= 1'b0;
    else if ((rise && ctrl1[C1_RISE]) || (fall && ctrl1[C1_FALL]))
      flag_q <= 1'b1;
    else if (flag_clear)
      flag_q <= 1'b0;
  end

  assign result     = result_q;
  assign ext_result = ctrl0[C0_SYNC] ? sync_q : post_pol;
  assign event_flag = flag_q;

endmodule

// [design/cmp_ctrl_pkg.sv]
package cmp_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL0_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL1_ONE = 8'h04;
  localparam logic [7:0] ADDR_CTRL0_TWO = 8'h08;
  localparam logic [7:0] ADDR_CTRL1_TWO = 8'h0c;
  localparam logic [7:0] ADDR_MIRROR    = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLR   = 8'h1c;

  // ----------------------------------------------------------------
  // Control register zero fields
  // ----------------------------------------------------------------
  localparam int C0_ON     = 7;
  localparam int C0_RESULT = 6;
  localparam int C0_PIN_EN = 5;
  localparam int C0_INVERT = 4;
  localparam int C0_SPEED  = 2;
  localparam int C0_HYST   = 1;
  localparam int C0_SYNC   = 0;

  // Writable mask and reset value of control zero (result bit is read only)
  localparam logic [7:0] C0_WMASK = 8'hb7;
  localparam logic [7:0] C0_RESET = 8'h04;

  // ----------------------------------------------------------------
  // Control register one fields
  // ----------------------------------------------------------------
  localparam int C1_RISE  = 7;
  localparam int C1_FALL  = 6;
  localparam int C1_PSEL  = 4;
  localparam int C1_NSEL  = 0;
  localparam logic [7:0] C1_WMASK = 8'hf3;
  localparam logic [7:0] C1_RESET = 8'h00;

  // Positive input routing codes
  localparam logic [1:0] PSEL_PIN    = 2'h0;
  localparam logic [1:0] PSEL_DAC    = 2'h1;
  localparam logic [1:0] PSEL_FIXED  = 2'h2;
  localparam logic [1:0] PSEL_SHARED = 2'h3;

  localparam int NUM_CMP = 2;

endpackage

// [design/dual_comparator_control.sv]
`timescale 1ns/100ps
// Function
// - Result reads one when positive above
// - Invert bit complements reported result
// - Pin enable drives result out, only with output direction
// - Speed select resets to one
// - Hysteresis bit switches hysteresis
// - Sync mode updates on Timer1 falling
// - Rise enable sets flag on rise
// - Fall enable sets flag on fall
// - Positive input select routes positive node
// - Negative input select picks shared pin
// - Mirror register holds both results
// - Unimplemented bits read zero
// - Reset restores documented values
// - Edge during clear leaves flag set
// - Internal result latched every cycle
// - Sync latch uses prescaled Timer1 clock
module dual_comparator_control
  import cmp_ctrl_pkg::*;
(
  // APB
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // Analog cores and Timer1
  input  wire logic [NUM_CMP-1:0]  raw_compare,
  input  wire logic [NUM_CMP-1:0]  tmr1_clk,
  input  wire logic [NUM_CMP-1:0]  pin_direction_out,
  // Analog controls
  output logic [NUM_CMP-1:0]       comparator_on,
  output logic [NUM_CMP-1:0]       speed_power_select,
  output logic [NUM_CMP-1:0]       hysteresis_enable,
  output logic [1:0]               positive_input_select [NUM_CMP],
  output logic [1:0]               negative_input_select [NUM_CMP],
  // Results
  output logic [NUM_CMP-1:0]       result_pin_out,
  output logic [NUM_CMP-1:0]       result_pin_oe,
  output logic [NUM_CMP-1:0]       timer_gate_result,
  output logic [NUM_CMP-1:0]       compare_event_flag,
  output logic                     irq
);

  logic [7:0]         ctrl0_q [NUM_CMP];
  logic [7:0]         ctrl1_q [NUM_CMP];
  logic [NUM_CMP-1:0] irq_en_q;
  logic [NUM_CMP-1:0] result;
  logic [NUM_CMP-1:0] ext_result;
  logic [NUM_CMP-1:0] flag;
  logic [NUM_CMP-1:0] flag_clear;
  logic               wr_en;
  logic               rd_en;
  logic [31:0]        rd_d;
  logic               err_d;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_CMP; i++)
        ctrl0_q[i] <= C0_RESET;
    end
    else if (wr_en && !pready)
    begin
      case (paddr)
        ADDR_CTRL0_ONE: ctrl0_q[0] <= pwdata[7:0] & C0_WMASK;
        ADDR_CTRL0_TWO: ctrl0_q[1] <= pwdata[7:0] & C0_WMASK;
        default:        ctrl0_q[0] <= ctrl0_q[0];
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_CMP; i++)
        ctrl1_q[i] <= C1_RESET;
    end
    else if (wr_en && !pready)
    begin
      case (paddr)
        ADDR_CTRL1_ONE: ctrl1_q[0] <= pwdata[7:0] & C1_WMASK;
        ADDR_CTRL1_TWO: ctrl1_q[1] <= pwdata[7:0] & C1_WMASK;
        default:        ctrl1_q[0] <= ctrl1_q[0];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt enable
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_en_q <= '0;
    else if (wr_en && !pready && paddr == ADDR_IRQ_EN)
      irq_en_q <= pwdata[NUM_CMP-1:0];
  end

  always_comb
  begin
    flag_clear = '0;
    if (wr_en && !pready && paddr == ADDR_IRQ_CLR)
      flag_clear = pwdata[NUM_CMP-1:0];
  end

  // ----------------------------------------------------------------
  // Comparator channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_CMP; g++)
  begin : g_ch
    cmp_channel u_ch
    (
      .pclk        (pclk),
      .presetn     (presetn),
      .ctrl0       (ctrl0_q[g]),
      .ctrl1       (ctrl1_q[g]),
      .flag_clear  (flag_clear[g]),
      .raw_compare (raw_compare[g]),
      .tmr1_clk    (tmr1_clk[g]),
      .result      (result[g]),
      .ext_result  (ext_result[g]),
      .event_flag  (flag[g])
    );
  end

  // ----------------------------------------------------------------
  // Analog control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      comparator_on <= '0;
    else
    begin
      for (int i = 0; i < NUM_CMP; i++)
        comparator_on[i] <= ctrl0_q[i][C0_ON];
    end
  end

  // Speed select comes out of reset in the fast mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      speed_power_select <= '1;
    else
    begin
      for (int i = 0; i < NUM_CMP; i++)
        speed_power_select[i] <= ctrl0_q[i][C0_SPEED];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hysteresis_enable <= '0;
    else
    begin
      for (int i = 0; i < NUM_CMP; i++)
        hysteresis_enable[i] <= ctrl0_q[i][C0_HYST];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_CMP; i++)
        positive_input_select[i] <= PSEL_PIN;
    end
    else
    begin
      for (int i = 0; i < NUM_CMP; i++)
        positive_input_select[i] <= ctrl1_q[i][C1_PSEL +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_CMP; i++)
        negative_input_select[i] <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < NUM_CMP; i++)
        negative_input_select[i] <= ctrl1_q[i][C1_NSEL +: 2];
    end
  end

  // ----------------------------------------------------------------
  // Result and flag outputs
  // ----------------------------------------------------------------
  // Pin driver only when the pin direction is output as well
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result_pin_oe <= '0;
    else
    begin
      for (int i = 0; i < NUM_CMP; i++)
        result_pin_oe[i] <= ctrl0_q[i][C0_PIN_EN] & pin_direction_out[i];
    end
  end

  // Pin and Timer1 see the same result, re-timed or not
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result_pin_out <= '0;
    else
      result_pin_out <= ext_result;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_gate_result <= '0;
    else
      timer_gate_result <= ext_result;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      compare_event_flag <= '0;
    else
      compare_event_flag <= flag;
  end

  // Only enabled flags reach the interrupt line
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(flag & irq_en_q);
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    case (paddr)
      ADDR_CTRL0_ONE: rd_d[7:0] = (ctrl0_q[0] & C0_WMASK) | {1'b0, result[0], 6'h00};
      ADDR_CTRL1_ONE: rd_d[7:0] = ctrl1_q[0];
      ADDR_CTRL0_TWO: rd_d[7:0] = (ctrl0_q[1] & C0_WMASK) | {1'b0, result[1], 6'h00};
      ADDR_CTRL1_TWO: rd_d[7:0] = ctrl1_q[1];
      ADDR_MIRROR:    rd_d[7:0] = {6'h00, result[1], result[0]};
      ADDR_IRQ_STAT:  rd_d[NUM_CMP-1:0] = flag;
      ADDR_IRQ_EN:    rd_d[NUM_CMP-1:0] = irq_en_q;
      ADDR_IRQ_CLR:   rd_d = 32'h0000_0000;
      default:        err_d = 1'b1;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel && penable && !pready;
  end

  // Read data is captured with the answer and held until the next one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && penable && !pready)
      prdata <= rd_en ? rd_d : 32'h0000_0000;
  end

  // Error only for an unmapped address, alongside pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= psel && penable && !pready && err_d;
  end

endmodule

// [tb/cmp_analog_model.sv]
`timescale 1ns/100ps
module cmp_analog_model #(
  parameter int PRESCALE = 3
) (
  // Clock
  input  wire logic       pclk,
  // Core controls and analog stimulus
  input  wire logic [1:0] comparator_on,
  input  wire logic [1:0] vp_above,
  input  wire logic [1:0] tmr_run,
  // Toward the control block
  output logic      [1:0] raw_compare,
  output logic      [1:0] tmr1_clk
);
  int         div_q = 0;
  logic [1:0] clk_q = 2'h0;
  // A core that is switched off compares nothing and stays low
  assign raw_compare = vp_above & comparator_on;
  // Prescaled timer clock, frozen at its last level while stopped
  always_ff @(posedge pclk)
  begin
    div_q <= (div_q == PRESCALE - 1) ? 0 : div_q + 1;
    if (div_q == 0)
      clk_q <= clk_q ^ tmr_run;
  end
  assign tmr1_clk = clk_q;
endmodule

// [tb/cmp_ctrl_chk.sv]
`timescale 1ns/100ps
module cmp_ctrl_chk
  import cmp_ctrl_pkg::*;
(
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  // Comparator side
  input wire logic [1:0]  pin_direction_out,
  input wire logic [1:0]  comparator_on,
  input wire logic [1:0]  speed_power_select,
  input wire logic [1:0]  hysteresis_enable,
  input wire logic [1:0]  result_pin_oe,
  input wire logic [1:0]  compare_event_flag,
  input wire logic        irq
);
  logic acc;
  logic rd;
  logic clr;
  assign acc = psel && penable && pwrite && !pready;
  assign rd = pready && !pwrite;
  assign clr = acc && paddr == ADDR_IRQ_CLR && pwdata[1];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_reset_speed: assert property ($rose(presetn) |-> speed_power_select == 2'h3)
    else $error("speed select not one after reset");
  chk_on_follows: assert property (acc && paddr == ADDR_CTRL0_ONE |-> ##2
    comparator_on[0] == $past(pwdata[7], 2)) else $error("enable bit not applied");
  chk_hyst_follows: assert property (acc && paddr == ADDR_CTRL0_TWO |=> ##1
    hysteresis_enable[1] == $past(pwdata[1], 2)) else $error("hysteresis not applied");
  chk_oe_needs_dir: assert property (result_pin_oe[0] |-> $past(pin_direction_out[0]))
    else $error("pin driven without output direction");
  chk_irq_has_flag: assert property (irq |-> compare_event_flag != 2'h0)
    else $error("interrupt without flag");
  chk_flag_sticky: assert property ($fell(compare_event_flag[1]) |-> $past(clr) || $past(clr, 2))
    else $error("flag dropped without clear");
  chk_mirror_zero: assert property (rd && paddr == ADDR_MIRROR |-> prdata[31:2] == 30'h0)
    else $error("mirror upper bits not zero");
  chk_ctrl_zero: assert property (rd && paddr == ADDR_CTRL0_ONE |-> !prdata[3])
    else $error("control bit three not zero");
  cover property (clr);
  cover property ($rose(irq));
  cover property ($rose(result_pin_oe[0]));
endmodule

bind dual_comparator_control cmp_ctrl_chk chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .prdata, .pin_direction_out, .comparator_on,
  .speed_power_select, .hysteresis_enable, .result_pin_oe, .compare_event_flag, .irq);

// [tb/tb.sv]
`timescale 1ns/100ps
module tb;
  import cmp_ctrl_pkg::*;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [NUM_CMP-1:0] raw_compare, tmr1_clk, pin_direction_out, comparator_on, above, run;
  logic [NUM_CMP-1:0] speed_power_select, hysteresis_enable, result_pin_out, result_pin_oe;
  logic [NUM_CMP-1:0] timer_gate_result, compare_event_flag;
  logic [1:0]         positive_input_select [NUM_CMP];
  logic [1:0]         negative_input_select [NUM_CMP];
  int                 mismatches, check_count;

  dual_comparator_control uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .raw_compare, .tmr1_clk, .pin_direction_out, .comparator_on,
    .speed_power_select, .hysteresis_enable, .positive_input_select, .negative_input_select,
    .result_pin_out, .result_pin_oe, .timer_gate_result, .compare_event_flag, .irq);
  cmp_analog_model model (.pclk, .comparator_on, .vp_above(above), .tmr_run(run),
    .raw_compare, .tmr1_clk);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic t_reset;
    apb(0, ADDR_CTRL0_ONE, 0);
    chk(rd, {24'h0, C0_RESET});
    apb(0, ADDR_CTRL1_TWO, 0);
    chk(rd, 32'h0);
    apb(0, ADDR_MIRROR, 0);
    chk(rd, 32'h0);
    chk(32'(speed_power_select), 32'h3);
  endtask

  task automatic t_regs;
    apb(1, ADDR_CTRL0_ONE, 32'hffff_ffff);
    apb(0, ADDR_CTRL0_ONE, 0);
    chk(rd, 32'hf7);
    chk(32'({comparator_on[0], hysteresis_enable[0], speed_power_select[0]}), 32'h7);
    apb(0, 8'h20, 0);
    chk({rd[30:0], err}, 32'h1);
  endtask

  task automatic t_pin;
    chk(32'(result_pin_oe[0]), 32'h0);
    pin_direction_out[0] <= 1'b1;
    run[0] <= 1'b1;
    repeat (30) @(posedge pclk);
    chk(32'(result_pin_oe[0]), 32'h1);
    chk(32'({result_pin_out[0], timer_gate_result[0]}), 32'h3);
    run[0] <= 1'b0;
    repeat (3) @(posedge pclk);
    above[0] <= 1'b1;
    repeat (30) @(posedge pclk);
    chk(32'(result_pin_out[0]), 32'h1);
    apb(0, ADDR_CTRL0_ONE, 0);
    chk(rd, 32'hb7);
    run[0] <= 1'b1;
    repeat (30) @(posedge pclk);
    chk(32'({result_pin_out[0], timer_gate_result[0]}), 32'h0);
  endtask

  task automatic t_result;
    above[1] <= 1'b1;
    apb(1, ADDR_CTRL0_TWO, 32'h80);
    apb(0, ADDR_MIRROR, 0);
    chk(rd, 32'h2);
    apb(0, ADDR_CTRL0_TWO, 0);
    chk(rd, 32'hc0);
    // Comparator two runs without re-timing: pin and Timer1 follow at once
    chk(32'({result_pin_out[1], timer_gate_result[1]}), 32'h3);
  endtask

  task automatic t_edge;
    apb(1, ADDR_CTRL1_TWO, 32'h80);
    apb(1, ADDR_IRQ_EN, 32'h2);
    apb(1, ADDR_IRQ_CLR, 32'h3);
    above[1] <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(32'({compare_event_flag, irq}), 32'h0);
    above[1] <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(32'({compare_event_flag, irq}), 32'h5);
    apb(1, ADDR_IRQ_EN, 0);
    chk(32'(irq), 32'h0);
    apb(1, ADDR_IRQ_CLR, 32'h2);
    apb(0, ADDR_IRQ_STAT, 0);
    chk(rd, 32'h0);
    apb(1, ADDR_CTRL1_TWO, 32'h40);
    above[1] <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(32'(compare_event_flag), 32'h2);
    // A rising edge lands on the very edge that takes the clear
    apb(1, ADDR_CTRL1_TWO, 32'hc0);
    fork
      apb(1, ADDR_IRQ_CLR, 32'h2);
      begin
        @(posedge pclk);
        above[1] <= 1'b1;
      end
    join
    apb(0, ADDR_IRQ_STAT, 0);
    chk(rd, 32'h2);
  endtask

  task automatic t_select;
    for (int k = 0; k < 4; k++)
    begin
      apb(1, ADDR_CTRL1_ONE, 32'(k * 16 + 3 - k));
      chk(32'(positive_input_select[0]), 32'(k));
      chk(32'(negative_input_select[0]), 32'(3 - k));
    end
  endtask

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial
  begin
    #200000;
    mismatches++;
    stop_test();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {pin_direction_out, above, run} = '0;
    mismatches = 0;
    check_count = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_regs();
    t_pin();
    t_result();
    t_edge();
    t_select();
    stop_test();
  end
endmodule
